// ### rtl/sci_top.sv
// fault interrupt status/clear and reset cause record, axi4-lite slave
//
// Functional notes
// [RQ1] masked bit is raw AND mask, drives irq
// [RQ2] write one clears masked and raw bit
// [RQ3] bit 6 set on pll lock timer
// [RQ4] bit 5 set on current limit detect
// [RQ5] bit 4 set on internal oscillator fault
// [RQ6] bit 3 set on main oscillator fault
// [RQ7] bit 2 set on unregulated ldo
// [RQ8] bit 1 brownout, needs mask and select clear
// [RQ9] bit 0 set when pll stops
// [RQ10] upper status bits undefined, software preserves
// [RQ11] cause record set by reset, no fixed value
// [RQ12] pin reset sets bit 0, clears others
// [RQ13] other resets accumulate onto previous causes
// [RQ14] cause bit 5 on regulator power loss
// [RQ15] cause bit 4 on software reset
// [RQ16] cause bit 3 on watchdog reset
// [RQ17] cause bit 2 on brownout reset
// [RQ18] cause bit 1 on power-on reset
// [RQ19] cause bit 0 on external pin reset
// [RQ20] mask bits reset to zero, gate interrupt
// [RQ21] irq high while any masked bit set
// [RQ22] software writes store the cause record
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module sci_top
    import sci_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output var  logic              s_awready,
    input  wire logic [DATA_W-1:0] s_wdata,
    input  wire logic [STRB_W-1:0] s_wstrb,
    input  wire logic              s_wvalid,
    output var  logic              s_wready,
    output var  logic [1:0]        s_bresp,
    output var  logic              s_bvalid,
    input  wire logic              s_bready,
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output var  logic              s_arready,
    output var  logic [DATA_W-1:0] s_rdata,
    output var  logic [1:0]        s_rresp,
    output var  logic              s_rvalid,
    input  wire logic              s_rready,
    input  wire logic              pll_fault_det,
    input  wire logic              brownout_det,
    input  wire logic              ldo_unreg_det,
    input  wire logic              main_osc_fault_det,
    input  wire logic              int_osc_fault_det,
    input  wire logic              current_limit_det,
    input  wire logic              pll_lock_timer_done,
    input  wire logic              brownout_irq_or_reset_select,
    input  wire logic              pin_reset_cause,
    input  wire logic              por_reset_cause,
    input  wire logic              brownout_reset_cause,
    input  wire logic              watchdog_reset_cause,
    input  wire logic              software_reset_cause,
    input  wire logic              ldo_reset_cause,
    output var  logic              fault_irq
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // map a byte address onto a register
    function automatic sci_reg_e reg_sel(input logic [ADDR_W-1:0] a);
        sci_reg_e s;
        if (a == RAW_OFS) begin
            s = SCI_REG_RAW;
        end else if (a == MASK_OFS) begin
            s = SCI_REG_MASK;
        end else if (a == MISC_OFS) begin
            s = SCI_REG_MISC;
        end else if (a == RESET_SOURCE_RECORD_OFS) begin
            s = SCI_REG_RESET_SOURCE_RECORD;
        end else begin
            s = SCI_REG_NONE;
        end
        return s;
    endfunction

    // masked status; brownout only when the select routes it to irq
    function automatic logic [NFAULT-1:0] masked_of(
        input logic [NFAULT-1:0] raw,
        input logic [NFAULT-1:0] mask,
        input logic              bor_to_reset
    );
        logic [NFAULT-1:0] m;
        m = raw & mask;                                // RQ1
        if (bor_to_reset) begin
            m[F_BROWN] = 1'b0;                         // RQ8
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // state and input bundles
    // ------------------------------------------------------------------
    sci_state_s        st;
    sci_state_s        next_st;
    logic [NFAULT-1:0] flt_in;
    logic [NCAUSE-1:0] cause_in;
    logic              wr_do;
    sci_reg_e          wr_sel;
    logic [NFAULT-1:0] wr_clr;

    // gather detector and cause inputs into vectors
    always_comb begin
        flt_in            = FLT_ZERO;
        flt_in[F_PLLFLT]  = pll_fault_det;             // RQ9
        flt_in[F_BROWN]   = brownout_det;              // RQ8
        flt_in[F_LDO]     = ldo_unreg_det;             // RQ7
        flt_in[F_MOSC]    = main_osc_fault_det;        // RQ6
        flt_in[F_IOSC]    = int_osc_fault_det;         // RQ5
        flt_in[F_CURLIM]  = current_limit_det;         // RQ4
        flt_in[F_PLLLOCK] = pll_lock_timer_done;       // RQ3
        cause_in          = '0;
        cause_in[C_PIN]   = pin_reset_cause;           // RQ19
        cause_in[C_POR]   = por_reset_cause;           // RQ18
        cause_in[C_BROWN] = brownout_reset_cause;      // RQ17
        cause_in[C_WDT]   = watchdog_reset_cause;      // RQ16
        cause_in[C_SW]    = software_reset_cause;      // RQ15
        cause_in[C_LDO]   = ldo_reset_cause;           // RQ14
    end

    // write commit happens once both halves are held
    assign wr_do  = st.aw_held && st.w_held && !st.bvalid;
    assign wr_sel = reg_sel(st.awaddr);
    assign wr_clr = (wr_do && wr_sel == SCI_REG_MISC && st.wstrb[LANE0])
                  ? st.wdata[NFAULT-1:0] : FLT_ZERO;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // two-stage synchronisers, running through reset too
        next_st.flt_s1   = flt_in;
        next_st.flt_s2   = st.flt_s1;
        next_st.cause_s1 = cause_in;
        next_st.cause_s2 = st.cause_s1;

        if (!aresetn) begin
            // the cause record is deliberately left untouched
            next_st.in_reset = 1'b1;
            next_st.raw      = FLT_ZERO;
            next_st.mask     = FLT_ZERO;               // RQ20
            next_st.irq      = 1'b0;
            next_st.aw_held  = 1'b0;
            next_st.w_held   = 1'b0;
            next_st.awready  = 1'b0;
            next_st.wready   = 1'b0;
            next_st.bvalid   = 1'b0;
            next_st.bresp    = RESP_OKAY;
            next_st.arready  = 1'b0;
            next_st.rvalid   = 1'b0;
            next_st.rdata    = ZERO_WORD;
            next_st.rresp    = RESP_OKAY;
        end else begin
            // capture the cause of the reset just released
            if (st.in_reset) begin
                next_st.in_reset = 1'b0;
                if (st.cause_s2[C_PIN]) begin
                    next_st.record = PIN_ONLY;                 // RQ12
                end else begin
                    next_st.record = st.record | st.cause_s2;  // RQ13 RQ11
                end
            end

            // write address and data channels, taken in either order
            if (s_awvalid && st.awready) begin
                next_st.aw_held = 1'b1;
                next_st.awaddr  = s_awaddr;
            end
            if (s_wvalid && st.wready) begin
                next_st.w_held = 1'b1;
                next_st.wdata  = s_wdata;
                next_st.wstrb  = s_wstrb;
            end

            // commit a held write and raise the response
            if (wr_do) begin
                next_st.aw_held = 1'b0;
                next_st.w_held  = 1'b0;
                next_st.bvalid  = 1'b1;
                next_st.bresp   = RESP_OKAY;
                case (wr_sel)
                    SCI_REG_MASK: begin
                        if (st.wstrb[LANE0]) begin
                            next_st.mask = st.wdata[NFAULT-1:0];
                        end
                    end
                    SCI_REG_RESET_SOURCE_RECORD: begin
                        if (st.wstrb[LANE0]) begin
                            next_st.record = st.wdata[NCAUSE-1:0];  // RQ22
                        end
                    end
                    SCI_REG_NONE: begin
                        next_st.bresp = RESP_SLVE;
                    end
                    default: begin
                        // raw is read-only, status clears below
                    end
                endcase
            end else if (st.bvalid && s_bready) begin
                next_st.bvalid = 1'b0;
            end

            // write one clears raw bit; a new event wins over the clear
            next_st.raw = (st.raw & ~wr_clr) | st.flt_s2;  // RQ2 RQ3

            // read channel, answered one cycle after the address
            if (s_arvalid && st.arready) begin
                next_st.rvalid = 1'b1;
                next_st.rresp  = RESP_OKAY;
                next_st.rdata  = ZERO_WORD;            // RQ10
                case (reg_sel(s_araddr))
                    SCI_REG_RAW: begin
                        next_st.rdata[NFAULT-1:0] = st.raw;
                    end
                    SCI_REG_MASK: begin
                        next_st.rdata[NFAULT-1:0] = st.mask;
                    end
                    SCI_REG_MISC: begin
                        next_st.rdata[NFAULT-1:0] = masked_of(
                            st.raw, st.mask, brownout_irq_or_reset_select);
                    end
                    SCI_REG_RESET_SOURCE_RECORD: begin
                        next_st.rdata[NCAUSE-1:0] = st.record;
                    end
                    default: begin
                        next_st.rresp = RESP_SLVE;
                    end
                endcase
            end else if (st.rvalid && s_rready) begin
                next_st.rvalid = 1'b0;
            end

            // readies drop while a transfer is held or unanswered
            next_st.awready = !next_st.aw_held && !next_st.bvalid;
            next_st.wready  = !next_st.w_held && !next_st.bvalid;
            next_st.arready = !next_st.rvalid;

            // single interrupt line from the masked status
            next_st.irq = |masked_of(next_st.raw, next_st.mask,
                                     brownout_irq_or_reset_select);  // RQ21
        end
    end

    // register the whole state
    always_ff @(posedge aclk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign s_awready = st.awready;
    assign s_wready  = st.wready;
    assign s_bvalid  = st.bvalid;
    assign s_bresp   = st.bresp;
    assign s_arready = st.arready;
    assign s_rvalid  = st.rvalid;
    assign s_rdata   = st.rdata;
    assign s_rresp   = st.rresp;
    assign fault_irq = st.irq;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic [NFAULT-1:0] bor_bit;
    assign bor_bit = 7'h02;

    // irq matches the masked status of the same cycle
    irq_from_mask_a: assert property ( // RQ1 RQ21
        $past(aresetn) |-> st.irq == |masked_of(st.raw, st.mask,
                                  $past(brownout_irq_or_reset_select)))
        else $error("irq does not follow masked status");

    // a write of one clears the raw bit when no event is pending
    w1c_clears_a: assert property ( // RQ2
        (wr_clr != FLT_ZERO) |=>
            ((st.raw & $past(wr_clr & ~st.flt_s2)) == FLT_ZERO))
        else $error("status bit survived a write of one");

    // every synchronised event lands in the raw status
    event_sets_a: assert property ( // RQ3 RQ4 RQ5 RQ6 RQ7 RQ9
        (st.flt_s2 != FLT_ZERO) |=>
            ((st.raw & $past(st.flt_s2)) == $past(st.flt_s2)))
        else $error("fault event lost");

    // brownout routed to reset never raises irq on its own
    bor_gate_a: assert property ( // RQ8
        ($past(brownout_irq_or_reset_select) && $past(aresetn) &&
         ((st.raw & st.mask & ~bor_bit) == FLT_ZERO)) |-> !st.irq)
        else $error("brownout irq while routed to reset");

    // masks come out of reset cleared
    mask_reset_a: assert property ( // RQ20
        $rose(aresetn) |-> (st.mask == FLT_ZERO && !st.irq))
        else $error("mask not cleared by reset");

    // a pin reset leaves only the pin cause
    pin_cause_a: assert property ( // RQ12 RQ19
        (st.in_reset && st.cause_s2[C_PIN]) |=> st.record == PIN_ONLY)
        else $error("pin reset did not clear other causes");

    // any other reset adds its cause to the old ones
    cause_sticky_a: assert property ( // RQ13 RQ14 RQ15 RQ16 RQ17 RQ18
        (st.in_reset && !st.cause_s2[C_PIN]) |=>
            st.record == ($past(st.record) | $past(st.cause_s2)))
        else $error("reset causes not accumulated");

    // software write stores the cause record
    reset_source_record_write_a: assert property ( // RQ22
        (wr_do && wr_sel == SCI_REG_RESET_SOURCE_RECORD && st.wstrb[LANE0]) |=>
            st.record == $past(st.wdata[NCAUSE-1:0]))
        else $error("cause record write not stored");

    // write response held until taken, awready low meanwhile
    bresp_hold_a: assert property (
        (st.bvalid && !s_bready) |=> (st.bvalid && !st.awready))
        else $error("write response dropped early");

endmodule

`default_nettype wire

// ### rtl/sci_pkg.sv
// constants and state type for the fault status and reset cause block
package sci_pkg;

    // ------------------------------------------------------------------
    // bus geometry and register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W    = 12;
    localparam int          DATA_W    = 32;
    localparam int          STRB_W    = 4;
    localparam int          LANE0     = 0;
    localparam logic [11:0] RAW_OFS   = 12'h050;
    localparam logic [11:0] MASK_OFS  = 12'h054;
    localparam logic [11:0] MISC_OFS  = 12'h058;
    localparam logic [11:0] RESET_SOURCE_RECORD_OFS  = 12'h05c;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLVE = 2'h2;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // fault event bit positions
    // ------------------------------------------------------------------
    localparam int NFAULT    = 7;
    localparam int F_PLLFLT  = 0;
    localparam int F_BROWN   = 1;
    localparam int F_LDO     = 2;
    localparam int F_MOSC    = 3;
    localparam int F_IOSC    = 4;
    localparam int F_CURLIM  = 5;
    localparam int F_PLLLOCK = 6;
    localparam logic [NFAULT-1:0] FLT_ZERO = 7'h00;

    // ------------------------------------------------------------------
    // reset cause bit positions
    // ------------------------------------------------------------------
    localparam int NCAUSE  = 6;
    localparam int C_PIN   = 0;
    localparam int C_POR   = 1;
    localparam int C_BROWN = 2;
    localparam int C_WDT   = 3;
    localparam int C_SW    = 4;
    localparam int C_LDO   = 5;
    localparam logic [NCAUSE-1:0] PIN_ONLY = 6'h01;

    // register selected by an address
    typedef enum logic [2:0] {
        SCI_REG_NONE,
        SCI_REG_RAW,
        SCI_REG_MASK,
        SCI_REG_MISC,
        SCI_REG_RESET_SOURCE_RECORD
    } sci_reg_e;

    // all state of the block
    typedef struct packed {
        logic [NFAULT-1:0] flt_s1;
        logic [NFAULT-1:0] flt_s2;
        logic [NCAUSE-1:0] cause_s1;
        logic [NCAUSE-1:0] cause_s2;
        logic              in_reset;
        logic [NFAULT-1:0] raw;
        logic [NFAULT-1:0] mask;
        logic [NCAUSE-1:0] record;
        logic              irq;
        logic              aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic              w_held;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } sci_state_s;

endpackage

// ### sim/sci_event_src.sv
// fault detector and reset source model driving the block's event inputs
`timescale 1ns/10ps
`default_nettype none

module sci_event_src
    import sci_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic [NFAULT-1:0] evt_cmd,
    input  wire logic [NCAUSE-1:0] cause_cmd,
    input  wire logic              sel_cmd,
    output var  logic [NFAULT-1:0] det,
    output var  logic [NCAUSE-1:0] cause,
    output var  logic              bor_sel
);

    // ------------------------------------------------------------------
    // detector and reset source levels
    // ------------------------------------------------------------------
    // quiet sources at power up so no input floats
    initial begin
        det     = '0;
        cause   = '0;
        bor_sel = 1'b0;
    end

    // levels move just after an edge, like flags from the analog side
    always @(posedge aclk) begin
        det     <= evt_cmd;
        cause   <= cause_cmd;
        bor_sel <= sel_cmd;
    end

endmodule
`default_nettype wire

// ### sim/tb_sysctl_irq_status_reset_cause.sv
// self-checking bench for the fault status and reset cause block
`timescale 1ns/10ps
`default_nettype none

module tb_sysctl_irq_status_reset_cause
    import sci_pkg::*;
;
    logic              aclk, aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic              awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, rvalid, fault_irq;
    logic [1:0]        bresp, rresp;
    logic [NFAULT-1:0] evt_cmd, det;
    logic [NCAUSE-1:0] cause_cmd, cause;
    logic              sel_cmd, bor_sel;
    int                fail_count, n_compared;
    // reset causes in turn: watchdog, software, power loss, brownout,
    // power on, then the pin together with everything else
    logic [NCAUSE-1:0] seq [6] = '{6'h08, 6'h10, 6'h20, 6'h04, 6'h02, 6'h3f};

    // 200 MHz clock
    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;

    sci_event_src src (.aclk(aclk), .evt_cmd(evt_cmd), .cause_cmd(cause_cmd),
        .sel_cmd(sel_cmd), .det(det), .cause(cause), .bor_sel(bor_sel));

    sci_top DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
        .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready), .pll_fault_det(det[F_PLLFLT]),
        .brownout_det(det[F_BROWN]), .ldo_unreg_det(det[F_LDO]),
        .main_osc_fault_det(det[F_MOSC]), .int_osc_fault_det(det[F_IOSC]),
        .current_limit_det(det[F_CURLIM]),
        .pll_lock_timer_done(det[F_PLLLOCK]),
        .brownout_irq_or_reset_select(bor_sel),
        .pin_reset_cause(cause[C_PIN]), .por_reset_cause(cause[C_POR]),
        .brownout_reset_cause(cause[C_BROWN]),
        .watchdog_reset_cause(cause[C_WDT]),
        .software_reset_cause(cause[C_SW]), .ldo_reset_cause(cause[C_LDO]),
        .fault_irq(fault_irq));

    // ------------------------------------------------------------------
    // reporting and comparison
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic timeout();
        $display("Error at %0t: wait ran out", $time);
        fail_count++;
        summarize();
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_word(32'(got), 32'(exp));
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word(32'(got), 32'(exp));
    endtask

    // ------------------------------------------------------------------
    // bus and sequencing helpers
    // ------------------------------------------------------------------
    // one write: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] exp_resp);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 200);
        if (bvalid !== 1'b1) timeout();
        cmp_resp(bresp, exp_resp);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    // one read, data and response taken at the edge that shows rvalid
    task automatic rd(input logic [11:0] a, input logic [31:0] exp_d,
                      input logic [1:0] exp_resp);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        if (rvalid !== 1'b1) timeout();
        cmp_word(rdata, exp_d);
        cmp_resp(rresp, exp_resp);
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // hold reset 12 cycles with the given causes present at release
    task automatic do_reset(input logic [NCAUSE-1:0] c);
        cause_cmd <= c;
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        cause_cmd <= '0;
        @(posedge aclk);
    endtask

    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (fault_irq !== v && n < 40) begin
            @(posedge aclk);
            n++;
        end
        if (fault_irq !== v) timeout();
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0]       exp;
        logic [NCAUSE-1:0] acc;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {evt_cmd, cause_cmd, sel_cmd} = '0;
        aresetn = 1'b0;
        fail_count = 0;
        n_compared = 0;
        do_reset(PIN_ONLY);
        rd(MASK_OFS, ZERO_WORD, RESP_OKAY);
        rd(MISC_OFS, ZERO_WORD, RESP_OKAY);
        rd(RESET_SOURCE_RECORD_OFS, 32'h0000_0001, RESP_OKAY);
        cmp_bit(fault_irq, 1'b0);
        $display("test reset_values done");
        // every source in turn, all masks open; upper bits written as zero
        wr(MASK_OFS, 32'h0000_007f, RESP_OKAY);
        for (int k = 0; k < NFAULT; k++) begin
            exp = 32'h0000_0001 << k;
            evt_cmd <= exp[NFAULT-1:0];
            wait_irq(1'b1);
            rd(MISC_OFS, exp, RESP_OKAY);
            rd(RAW_OFS, exp, RESP_OKAY);
            evt_cmd <= '0;
            repeat (4) @(posedge aclk);
            wr(MISC_OFS, exp, RESP_OKAY);
            rd(RAW_OFS, ZERO_WORD, RESP_OKAY);
            cmp_bit(fault_irq, 1'b0);
        end
        $display("test each_source done");
        // masked source: raw set, no interrupt, zero write keeps it
        wr(MASK_OFS, ZERO_WORD, RESP_OKAY);
        evt_cmd <= 7'h08;
        repeat (8) @(posedge aclk);
        rd(RAW_OFS, 32'h0000_0008, RESP_OKAY);
        rd(MISC_OFS, ZERO_WORD, RESP_OKAY);
        cmp_bit(fault_irq, 1'b0);
        evt_cmd <= '0;
        repeat (4) @(posedge aclk);
        wr(MISC_OFS, ZERO_WORD, RESP_OKAY);
        rd(RAW_OFS, 32'h0000_0008, RESP_OKAY);
        wr(MISC_OFS, 32'h0000_0008, RESP_OKAY);
        rd(RAW_OFS, ZERO_WORD, RESP_OKAY);
        $display("test masked_source done");
        // brownout routed to reset must not interrupt
        wr(MASK_OFS, 32'h0000_007f, RESP_OKAY);
        sel_cmd <= 1'b1;
        evt_cmd <= 7'h02;
        repeat (8) @(posedge aclk);
        rd(MISC_OFS, ZERO_WORD, RESP_OKAY);
        cmp_bit(fault_irq, 1'b0);
        sel_cmd <= 1'b0;
        wait_irq(1'b1);
        rd(MISC_OFS, 32'h0000_0002, RESP_OKAY);
        evt_cmd <= '0;
        repeat (4) @(posedge aclk);
        wr(MISC_OFS, 32'h0000_0002, RESP_OKAY);
        wait_irq(1'b0);
        $display("test brownout_select done");
        // unmapped place answers with an error
        wr(12'h100, 32'h0000_007f, RESP_SLVE);
        rd(12'h100, ZERO_WORD, RESP_SLVE);
        $display("test unmapped done");
        // cause record: software clear, then accumulating resets
        wr(RESET_SOURCE_RECORD_OFS, ZERO_WORD, RESP_OKAY);
        rd(RESET_SOURCE_RECORD_OFS, ZERO_WORD, RESP_OKAY);
        acc = '0;
        foreach (seq[i]) begin
            do_reset(seq[i]);
            acc = seq[i][C_PIN] ? PIN_ONLY : (acc | seq[i]);
            rd(RESET_SOURCE_RECORD_OFS, 32'(acc), RESP_OKAY);
        end
        rd(MASK_OFS, ZERO_WORD, RESP_OKAY);
        $display("test reset_causes done");
        summarize();
    end

    // overall limit on run length
    initial begin
        repeat (20000) @(posedge aclk);
        timeout();
    end

endmodule
`default_nettype wire
